/* File: hdl/fuse_prog_host.sv */
// host controller that frames and sends fuse commands on the one-wire input
// Notes on behaviour
// - host blows only one fuse per word
// - host waits 1 ms after each blow
// - program other-functions bit0 blows master fuse
// - program uses function 10, one value bit
// - read uses function 11, value ignored
// - sense code bit0 set lowers current
// - sense code bit0 clear restores current
// - bench verifies programming by reading back
// - short pulse zero, long one, gaps
// - 38-bit word fields sent msb first
`timescale 1ns/10ps
`default_nettype none
module fuse_prog_host
(
  // clock, reset, enable
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  input  wire logic       clk_en_in,
  // user command port
  input  wire logic       cmd_valid_in,
  input  wire logic [1:0] cmd_func_in,
  input  wire logic [1:0] cmd_param_in,
  input  wire logic [7:0] cmd_value_in,
  output logic            cmd_ready_out,
  output logic            cmd_bad_out,
  output logic            read_valid_out,
  output logic [7:0]      read_data_out,
  // device pins
  output logic            serial_program_input_out,
  input  wire logic       readback_output_in
);
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_HIGH  = 3'b001,
    ST_GAP   = 3'b010,
    ST_BLOW  = 3'b011,
    ST_RDHI  = 3'b100,
    ST_RDGAP = 3'b101
  } state_t;

  typedef struct packed
  {
    state_t      st;
    logic [37:0] word;
    logic [5:0]  bit_cnt;
    logic [15:0] tmr;
    logic [3:0]  rd_cnt;
    logic [7:0]  rd_shift;
    logic        is_read;
    logic        is_prog;
    logic        pin;
    logic        bad;
    logic        rvalid;
    logic [7:0]  rdata;
    logic        sync1;
    logic        sync2;
  } state_s_t;

  state_s_t s_reg;
  state_s_t s_next;

  // one-hot check on a program value
  function automatic logic one_hot8(input logic [7:0] v);
    logic [7:0] m;
    m = v & (v - 8'h01);
    return (v != 8'h00) && (m == 8'h00);
  endfunction

  function automatic logic [15:0] width_of(input logic b);
    return b ? 16'(fuse_prog_pkg::ONE_CYC) : 16'(fuse_prog_pkg::ZERO_CYC);
  endfunction

  logic prog_ok;
  assign prog_ok = one_hot8(cmd_value_in);

  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = readback_output_in;
    s_next.sync2 = s_reg.sync1;
    s_next.rvalid = 1'b0;
    s_next.bad = 1'b0;
    unique case (s_reg.st)
      ST_IDLE:
      begin
        s_next.pin = 1'b0;
        if (cmd_valid_in)
        begin
          if (cmd_func_in == fuse_prog_pkg::FN_PROGRAM && !prog_ok)
          begin
            s_next.bad = 1'b1;
          end
          else
          begin
            // msb first, all functions
            s_next.word = {fuse_prog_pkg::START_PAT, cmd_func_in,
                           cmd_param_in, fuse_prog_pkg::DUMMY_PAT,
                           cmd_value_in, fuse_prog_pkg::END_PAT};
            s_next.is_read = (cmd_func_in == fuse_prog_pkg::FN_READ);
            s_next.is_prog = (cmd_func_in == fuse_prog_pkg::FN_PROGRAM);
            s_next.bit_cnt = 6'd0;
            s_next.pin = 1'b1;
            s_next.tmr = width_of(fuse_prog_pkg::START_PAT[11]);
            s_next.st = ST_HIGH;
          end
        end
      end
      ST_HIGH:
      begin
        // zero is a short pulse, one a long pulse
        if (s_reg.tmr <= 16'd1)
        begin
          s_next.pin = 1'b0;
          s_next.tmr = 16'(fuse_prog_pkg::GAP_CYC);
          s_next.st = ST_GAP;
        end
        else
        begin
          s_next.tmr = s_reg.tmr - 16'd1;
        end
      end
      ST_GAP:
      begin
        if (s_reg.tmr <= 16'd1)
        begin
          if (s_reg.bit_cnt == 6'(fuse_prog_pkg::WORD_BITS - 1))
          begin
            if (s_reg.is_prog)
            begin
              // pin stays low so the switch opens; wait out the blow
              s_next.tmr = 16'(fuse_prog_pkg::BLOW_CYC);
              s_next.st = ST_BLOW;
            end
            else if (s_reg.is_read)
            begin
              // msb is already on the readback pin
              s_next.rd_cnt = 4'd0;
              s_next.rd_shift = 8'h00;
              s_next.st = ST_RDHI;
              s_next.pin = 1'b1;
              s_next.tmr = width_of(1'b0);
            end
            else
            begin
              s_next.st = ST_IDLE;
            end
          end
          else
          begin
            s_next.bit_cnt = s_reg.bit_cnt + 6'd1;
            s_next.word = {s_reg.word[36:0], 1'b0};
            s_next.pin = 1'b1;
            s_next.tmr = width_of(s_reg.word[36]);
            s_next.st = ST_HIGH;
          end
        end
        else
        begin
          s_next.tmr = s_reg.tmr - 16'd1;
        end
      end
      ST_BLOW:
      begin
        if (s_reg.tmr <= 16'd1)
        begin
          s_next.st = ST_IDLE;
        end
        else
        begin
          s_next.tmr = s_reg.tmr - 16'd1;
        end
      end
      ST_RDHI:
      begin
        // sample before the falling edge shifts the next bit out
        if (s_reg.tmr == 16'(fuse_prog_pkg::ZERO_CYC))
        begin
          if (s_reg.rd_cnt < 4'(fuse_prog_pkg::READ_PULSES))
          begin
            s_next.rd_shift = {s_reg.rd_shift[6:0], s_reg.sync2};
          end
        end
        if (s_reg.tmr <= 16'd1)
        begin
          s_next.pin = 1'b0;
          s_next.rd_cnt = s_reg.rd_cnt + 4'd1;
          s_next.tmr = 16'(fuse_prog_pkg::GAP_CYC);
          s_next.st = ST_RDGAP;
        end
        else
        begin
          s_next.tmr = s_reg.tmr - 16'd1;
        end
      end
      ST_RDGAP:
      begin
        if (s_reg.tmr <= 16'd1)
        begin
          if (s_reg.rd_cnt == 4'(fuse_prog_pkg::READ_PULSES))
          begin
            // eighth pulse ended read mode; zeros pad short fields
            s_next.rvalid = 1'b1;
            s_next.rdata = s_reg.rd_shift;
            s_next.st = ST_IDLE;
          end
          else
          begin
            s_next.pin = 1'b1;
            s_next.tmr = width_of(1'b0);
            s_next.st = ST_RDHI;
          end
        end
        else
        begin
          s_next.tmr = s_reg.tmr - 16'd1;
        end
      end
      default:
      begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      s_reg <= '0;
    end
    else if (clk_en_in)
    begin
      s_reg <= s_next;
    end
  end

  // a sampling slot before the first falling edge picks up the msb
  assign cmd_ready_out            = (s_reg.st == ST_IDLE);
  assign cmd_bad_out              = s_reg.bad;
  assign read_valid_out           = s_reg.rvalid;
  assign read_data_out            = s_reg.rdata;
  assign serial_program_input_out = s_reg.pin;

  a_pulse_width_one: assert property (@(posedge core_clk_in)
    disable iff (srst_in)
    (s_reg.st == ST_GAP && clk_en_in && s_next.st == ST_HIGH
     && s_next.tmr == 16'(fuse_prog_pkg::ONE_CYC)) |=> serial_program_input_out)
    else $error("one pulse not started");
  a_gap_low: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (s_reg.st == ST_GAP) |-> !serial_program_input_out)
    else $error("pin high in gap");
  a_blow_wait: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (s_reg.st == ST_BLOW) |-> !serial_program_input_out && !cmd_ready_out)
    else $error("blow wait broken");
  a_prog_onehot: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cmd_ready_out && cmd_valid_in && clk_en_in
     && cmd_func_in == fuse_prog_pkg::FN_PROGRAM && !prog_ok) |=> cmd_bad_out)
    else $error("multi-bit program accepted");
  a_word_start: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (s_reg.st == ST_HIGH && s_reg.bit_cnt == 6'd0)
    |-> s_reg.word[37:26] == fuse_prog_pkg::START_PAT)
    else $error("bad start field");
  a_read_count: assert property (@(posedge core_clk_in) disable iff (srst_in)
    read_valid_out |-> s_reg.rd_cnt == 4'(fuse_prog_pkg::READ_PULSES))
    else $error("read ended at wrong pulse");
  a_read_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (s_reg.st == ST_RDHI) |-> serial_program_input_out)
    else $error("read pulse low");
  a_idle_low: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (s_reg.st == ST_IDLE) |-> !serial_program_input_out)
    else $error("pin high in idle");

  c_program: cover property (@(posedge core_clk_in) s_reg.st == ST_BLOW);
  c_read: cover property (@(posedge core_clk_in) read_valid_out);
  c_bad: cover property (@(posedge core_clk_in) cmd_bad_out);
endmodule
`default_nettype wire

/* File: inc/fuse_prog_pkg.sv */
// constants for the fuse programmer host
package fuse_prog_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned T_ZERO_NS      = 1000;
  localparam int unsigned T_ONE_US       = 60;
  localparam int unsigned T_GAP_US       = 12;
  localparam int unsigned T_BLOW_US      = 1000;
  localparam int unsigned ZERO_CYC       =
    (T_ZERO_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned ONE_CYC        = (T_ONE_US * (CLK_HZ / 1000000));
  localparam int unsigned GAP_CYC        = (T_GAP_US * (CLK_HZ / 1000000));
  localparam int unsigned BLOW_CYC       = (T_BLOW_US * (CLK_HZ / 1000000));
  localparam int unsigned WORD_BITS      = 38;
  localparam int unsigned READ_PULSES    = 8;
  localparam logic [11:0] START_PAT      = 12'h801;
  localparam logic [11:0] END_PAT        = 12'h7fe;
  localparam logic [1:0]  DUMMY_PAT      = 2'h2;
  localparam logic [1:0]  FN_SENSE       = 2'h0;
  localparam logic [1:0]  FN_PROGRAM     = 2'h2;
  localparam logic [1:0]  FN_READ        = 2'h3;
  localparam logic [1:0]  PAR_OTHER      = 2'h3;
  localparam logic [7:0]  MASTER_BIT     = 8'h01;
endpackage

/* File: sim/fuse_dev_model.sv */
// behavioural model of the trimmed amplifier behind the one-wire input
`timescale 1ns/10ps
`default_nettype none
module fuse_dev_model
(
  // device pins
  input  wire logic pin_in,
  output logic      rdbk_out,
  // observation
  output logic      viol_out,
  output logic      sense_low_out,
  output logic      read_mode_out
);
  logic [37:0] word_reg;
  logic [5:0]  nbits_reg;
  logic [7:0]  fuse_reg [4];
  logic [7:0]  msk [4] = '{8'h07, 8'h7f, 8'hff, 8'h03};
  logic [7:0]  shift_reg;
  logic [3:0]  rd_cnt_reg;
  logic        amp_reg;
  logic        lock_reg;
  realtime     t_rise;
  realtime     t_fall;
  realtime     t_blow;
  realtime     w;
  initial
  begin
    foreach (fuse_reg[i]) fuse_reg[i] = 8'h00;
    {word_reg, nbits_reg, rd_cnt_reg, shift_reg, amp_reg, lock_reg} = '0;
    {viol_out, sense_low_out, read_mode_out} = 3'h0;
    t_rise = 0.0;
    t_fall = -1.0e6;
    t_blow = -1.0e7;
  end
  // stand-in for the analog stage: toggles so stale data never matches
  always #100 amp_reg = ~amp_reg;
  assign rdbk_out = read_mode_out ? shift_reg[7] : amp_reg;
  always @(posedge pin_in)
  begin
    if ($realtime - t_fall < 1.0e4 || $realtime - t_blow < 1.0e6)
      viol_out = 1'b1;
    t_rise = $realtime;
  end
  task automatic decode();
    logic [1:0] fn;
    logic [1:0] par;
    logic [7:0] val;
    fn = word_reg[25:24];
    par = word_reg[23:22];
    val = word_reg[19:12];
    if (word_reg[37:26] != 12'h801 || word_reg[21:20] != 2'h2
        || word_reg[11:0] != 12'h7fe)
      return;
    if (fn == 2'h2 && !lock_reg)
    begin
      if ($countones(val) != 1)
        viol_out = 1'b1;
      fuse_reg[par] = fuse_reg[par] | (val & msk[par]);
      lock_reg = lock_reg | (par == 2'h3 && val[0]);
      t_blow = $realtime;
    end
    else if (fn == 2'h3)
    begin
      shift_reg = fuse_reg[par];
      rd_cnt_reg = 4'h0;
      read_mode_out = 1'b1;
    end
    else if (fn == 2'h0 && par == 2'h0)
      sense_low_out = val[0];
  endtask
  always @(negedge pin_in)
  begin
    t_fall = $realtime;
    w = t_fall - t_rise;
    if (read_mode_out)
    begin
      rd_cnt_reg = rd_cnt_reg + 4'h1;
      shift_reg = shift_reg << 1;
      if (rd_cnt_reg == 4'h8)
        read_mode_out = 1'b0;
    end
    else if ((w >= 50.0 && w <= 1.0e4) || w >= 5.0e4)
    begin
      word_reg = {word_reg[36:0], w >= 5.0e4};
      nbits_reg = nbits_reg + 6'h1;
      if (nbits_reg == 6'd38)
      begin
        decode();
        nbits_reg = 6'h0;
      end
    end
    else
      nbits_reg = 6'h0;
  end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the fuse programmer host
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb_top;
  logic       core_clk_in = 1'b0;
  logic       srst_in = 1'b1;
  logic       clk_en_in = 1'b1;
  logic       cmd_valid_in = 1'b0;
  logic [1:0] cmd_func_in = 2'h0;
  logic [1:0] cmd_param_in = 2'h0;
  logic [7:0] cmd_value_in = 8'h00;
  logic [7:0] read_data_out;
  logic       cmd_ready_out, cmd_bad_out, read_valid_out;
  logic       serial_program_input_out, readback_output_in;
  logic       viol, sense_low, rd_mode;
  int         err_count = 0;
  int         tests_run = 0;
  always #20 core_clk_in = ~core_clk_in;
  fuse_prog_host i_dut (.core_clk_in, .srst_in, .clk_en_in, .cmd_valid_in,
    .cmd_func_in, .cmd_param_in, .cmd_value_in, .cmd_ready_out, .cmd_bad_out,
    .read_valid_out, .read_data_out, .serial_program_input_out,
    .readback_output_in);
  fuse_dev_model i_dev (.pin_in(serial_program_input_out),
    .rdbk_out(readback_output_in), .viol_out(viol),
    .sense_low_out(sense_low), .read_mode_out(rd_mode));
  task end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task send(input logic [1:0] f, input logic [1:0] p, input logic [7:0] v);
    @(negedge core_clk_in);
    {cmd_func_in, cmd_param_in, cmd_value_in} = {f, p, v};
    cmd_valid_in = 1'b1;
    @(negedge core_clk_in);
    cmd_valid_in = 1'b0;
  endtask
  // bounded wait on ready or on read completion
  task wait_for(input bit rd, input int lim);
    int n;
    n = 0;
    while ((rd ? read_valid_out : cmd_ready_out) !== 1'b1 && n < lim)
    begin
      @(negedge core_clk_in);
      n++;
    end
    `CHK(n < lim, 1'b1)
  endtask
  task t_reset();
    repeat (6) @(negedge core_clk_in);
    srst_in = 1'b0;
    @(negedge core_clk_in);
    `CHK(cmd_ready_out, 1'b1)
    `CHK(serial_program_input_out, 1'b0)
    `CHK(sense_low, 1'b0)
  endtask
  // reset cuts a sense word mid-pulse; the 20 us stub must be discarded
  task t_abort();
    send(2'h0, 2'h0, 8'h01);
    `CHK(cmd_ready_out, 1'b0)
    `CHK(serial_program_input_out, 1'b1)
    repeat (500) @(negedge core_clk_in);
    srst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    srst_in = 1'b0;
    @(negedge core_clk_in);
    `CHK(cmd_ready_out, 1'b1)
    `CHK(serial_program_input_out, 1'b0)
    repeat (300) @(negedge core_clk_in);
    `CHK(sense_low, 1'b0)
  endtask
  // with the enable low a request must not be taken
  task t_freeze();
    @(negedge core_clk_in);
    clk_en_in = 1'b0;
    send(2'h2, 2'h0, 8'h02);
    repeat (2) @(negedge core_clk_in);
    `CHK(serial_program_input_out, 1'b0)
    `CHK(cmd_ready_out, 1'b1)
    clk_en_in = 1'b1;
  endtask
  task t_refuse();
    logic seen;
    seen = 1'b0;
    send(2'h2, 2'h0, 8'h03);
    repeat (3)
    begin
      seen = seen | cmd_bad_out;
      @(negedge core_clk_in);
    end
    `CHK(seen, 1'b1)
    `CHK(serial_program_input_out, 1'b0)
  endtask
  task t_program();
    send(2'h2, 2'h0, 8'h02);
    wait_for(1'b0, 70000);
    `CHK(viol, 1'b0)
  endtask
  task t_read();
    send(2'h3, 2'h0, 8'h00);
    wait_for(1'b1, 40000);
    `CHK(read_data_out, 8'h02)
    `CHK(rd_mode, 1'b0)
    `CHK(viol, 1'b0)
  endtask
  initial
  begin
    t_reset();
    t_abort();
    t_refuse();
    t_freeze();
    t_program();
    t_read();
    end_of_test();
  end
  initial
  begin
    repeat (100000) @(posedge core_clk_in);
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
